// file: src/egm_consts.vh
`ifndef EGM_CONSTS_VH
`define EGM_CONSTS_VH
// ----------------------------------------
// address map
// ----------------------------------------
`define EGM_ADDR_W 13
`define EGM_MAIN_CTRL0 13'h0400
`define EGM_MAIN_CTRL_BASE 13'h0400
`define EGM_GROUP_WIN_MASK 13'h003F
`define EGM_GROUP_SHIFT 6
`define EGM_IRQ_STATUS 13'h0410
`define EGM_IRQ_MASK 13'h0411
// ----------------------------------------
// main control fields
// ----------------------------------------
`define EGM_BIT_WR_ALL 7
`define EGM_BIT_OUT_EN 6
`define EGM_BIT_GIRQ_MASK 5
`define EGM_BIT_TONE_B_MASK 4
`define EGM_BIT_TONE_A_MASK 3
`define EGM_BIT_FORMAT 2
`define EGM_BIT_LAW 1
`define EGM_BIT_POWER_ON 0
`define EGM_CTRL_RESET 8'h00
`define EGM_GROUP_CTRL_MASK 8'h1F
// ----------------------------------------
// event bits
// ----------------------------------------
`define EGM_EV_WRITE 0
`define EGM_EV_TONE 1
`define EGM_EV_W 2
`endif

// file: src/egm_group_ctrl.v
`timescale 1ns/100ps
`include "egm_consts.vh"
// ----------------------------------------
// per-group main control register
// ----------------------------------------
module egm_group_ctrl (
    input wire clock_i,
    input wire rst_b_i,
    input wire wr_i,
    input wire [7:0] wdata_i,
    input wire tone_a_i,
    input wire tone_b_i,
    output wire [7:0] ctrl_o,
    output wire tone_irq_o
);
    reg [7:0] ctrl_reg;

    // low five bits only; upper positions have no function here
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= `EGM_CTRL_RESET; // RQ10
        end else if (wr_i) begin
            ctrl_reg <= wdata_i & `EGM_GROUP_CTRL_MASK; // RQ4
        end
    end

    assign ctrl_o = ctrl_reg;
    // per-detector masking
    assign tone_irq_o = (tone_a_i & ~ctrl_reg[`EGM_BIT_TONE_A_MASK]) |
                        (tone_b_i & ~ctrl_reg[`EGM_BIT_TONE_B_MASK]); // RQ9
endmodule // egm_group_ctrl

// file: src/egm_main_ctrl.v
// Functional notes
// RQ1 - with broadcast write set, a write to the group 0 window reaches all sixteen groups.
// RQ2 - with broadcast write clear, each group answers only at its own address range.
// RQ3 - software sets broadcast write to initialise every group like group 0 in one pass.
// RQ4 - broadcast, output enable and global mask exist only in the group 0 register.
// RQ5 - serial outputs drive only when the enable bit and the enable pin are both high.
// RQ6 - if either the enable bit or the pin is low, both serial outputs float.
// RQ7 - global mask set blocks all tone interrupts while detectors keep running.
// RQ8 - global mask clear lets tone interrupts pass subject to per-detector masks.
// RQ9 - each group's A and B mask bits block that group's A and B tone interrupts.
// RQ10 - all control registers clear to zero at reset.
`timescale 1ns/100ps
`include "egm_consts.vh"
module egm_main_ctrl #(
    parameter NGROUPS = 16
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire [12:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire out_en_pin_i,
    input wire rout_i,
    input wire sout_i,
    input wire [NGROUPS-1:0] tone_a_irq_i,
    input wire [NGROUPS-1:0] tone_b_irq_i,
    output reg rout_o,
    output reg rout_oe_o,
    output reg sout_o,
    output reg sout_oe_o,
    output reg tone_irq_o,
    output reg irq_o,
    output reg [NGROUPS-1:0] grp_sel_o,
    output reg grp_wr_o,
    output reg [5:0] grp_addr_o,
    output reg [7:0] grp_wdata_o,
    output reg [NGROUPS-1:0] power_on_o,
    output reg [NGROUPS-1:0] format_o,
    output reg [NGROUPS-1:0] law_o
);
    // ----------------------------------------
    // global bits of group 0, event status and mask, tone edge history
    // ----------------------------------------
    reg wr_all_reg;
    reg out_en_reg;
    reg girq_mask_reg;
    reg [`EGM_EV_W-1:0] irq_stat_reg;
    reg [`EGM_EV_W-1:0] irq_mask_reg;
    reg tone_prev_reg;

    wire [7:0] grp_ctrl [0:NGROUPS-1];
    wire [NGROUPS-1:0] grp_tone;
    wire [NGROUPS-1:0] grp_hit;
    wire [3:0] addr_grp;
    wire in_ctrl;
    wire ctrl_wr0;
    wire any_tone;
    wire tone_gated;
    wire drive_en;
    wire [`EGM_EV_W-1:0] ev_set;

    // control window decode: 0x400..0x40F
    assign in_ctrl = (addr_i[12:4] == `EGM_MAIN_CTRL_BASE >> 4);
    assign addr_grp = addr_i[3:0];
    assign ctrl_wr0 = wr_i & in_ctrl & (addr_grp == 4'h0);

    // ----------------------------------------
    // group instances and address decode
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NGROUPS; g = g + 1) begin : gen_grp
            wire sel_own;
            wire ctrl_wr;
            assign sel_own = (addr_i[12:`EGM_GROUP_SHIFT] == g);
            // broadcast maps every group onto the group 0 range
            assign grp_hit[g] = wr_all_reg ? (addr_i[12:`EGM_GROUP_SHIFT] == 0) // RQ1
                                           : sel_own; // RQ2
            assign ctrl_wr = wr_i & in_ctrl &
                             (wr_all_reg ? (addr_grp == 4'h0) : (addr_grp == g)); // RQ1
            egm_group_ctrl u_grp (
                .clock_i(clock_i),
                .rst_b_i(rst_b_i),
                .wr_i(ctrl_wr),
                .wdata_i(wdata_i),
                .tone_a_i(tone_a_irq_i[g]),
                .tone_b_i(tone_b_irq_i[g]),
                .ctrl_o(grp_ctrl[g]),
                .tone_irq_o(grp_tone[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // global control bits
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            wr_all_reg <= 1'b0; // RQ10
            out_en_reg <= 1'b0;
            girq_mask_reg <= 1'b0;
        end else if (ctrl_wr0) begin
            wr_all_reg <= wdata_i[`EGM_BIT_WR_ALL]; // RQ4
            out_en_reg <= wdata_i[`EGM_BIT_OUT_EN];
            girq_mask_reg <= wdata_i[`EGM_BIT_GIRQ_MASK];
        end
    end

    // global gate on the combined tone request
    assign any_tone = |grp_tone;
    assign tone_gated = any_tone & ~girq_mask_reg; // RQ7 RQ8
    assign drive_en = out_en_reg & out_en_pin_i; // RQ5

    // ----------------------------------------
    // serial output drive
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            rout_o <= 1'b0;
            sout_o <= 1'b0;
            rout_oe_o <= 1'b0;
            sout_oe_o <= 1'b0;
        end else begin
            rout_o <= rout_i;
            sout_o <= sout_i;
            rout_oe_o <= drive_en; // RQ5 RQ6
            sout_oe_o <= drive_en; // RQ6
        end
    end

    // ----------------------------------------
    // event status and mask
    // ----------------------------------------
    assign ev_set[`EGM_EV_WRITE] = ctrl_wr0;
    assign ev_set[`EGM_EV_TONE] = tone_gated & ~tone_prev_reg;

    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            irq_stat_reg <= {`EGM_EV_W{1'b0}};
            irq_mask_reg <= {`EGM_EV_W{1'b0}};
            tone_prev_reg <= 1'b0;
        end else begin
            tone_prev_reg <= tone_gated;
            // set beats write-one-to-clear
            if (wr_i && addr_i == `EGM_IRQ_STATUS) begin
                irq_stat_reg <= (irq_stat_reg & ~wdata_i[`EGM_EV_W-1:0]) | ev_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | ev_set;
            end
            if (wr_i && addr_i == `EGM_IRQ_MASK) begin
                irq_mask_reg <= wdata_i[`EGM_EV_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // interrupt outputs
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            tone_irq_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            tone_irq_o <= tone_gated; // RQ7
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // group register bus and decoded fields
    // ----------------------------------------
    integer i;
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            grp_sel_o <= {NGROUPS{1'b0}};
            grp_wr_o <= 1'b0;
            grp_addr_o <= 6'h00;
            grp_wdata_o <= 8'h00;
            power_on_o <= {NGROUPS{1'b0}};
            format_o <= {NGROUPS{1'b0}};
            law_o <= {NGROUPS{1'b0}};
        end else begin
            grp_sel_o <= (wr_i | rd_i) ? grp_hit : {NGROUPS{1'b0}}; // RQ1 RQ2
            grp_wr_o <= wr_i & (|grp_hit);
            grp_addr_o <= addr_i[5:0];
            grp_wdata_o <= wdata_i;
            for (i = 0; i < NGROUPS; i = i + 1) begin
                power_on_o[i] <= grp_ctrl[i][`EGM_BIT_POWER_ON];
                format_o[i] <= grp_ctrl[i][`EGM_BIT_FORMAT];
                law_o[i] <= grp_ctrl[i][`EGM_BIT_LAW];
            end
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    always @(posedge clock_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            if (in_ctrl) begin
                if (addr_grp == 4'h0) begin
                    rdata_o <= grp_ctrl[0] | {wr_all_reg, out_en_reg, girq_mask_reg, 5'h00};
                end else begin
                    rdata_o <= grp_ctrl[addr_grp];
                end
            end else if (addr_i == `EGM_IRQ_STATUS) begin
                rdata_o <= {6'h00, irq_stat_reg};
            end else if (addr_i == `EGM_IRQ_MASK) begin
                rdata_o <= {6'h00, irq_mask_reg};
            end else begin
                rdata_o <= 8'h00;
            end
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule // egm_main_ctrl

// file: dv/egm_main_ctrl_properties.sv
`timescale 1ns/100ps
module egm_main_ctrl_props #(
    parameter NGROUPS = 16
) (
    input wire clock_i,
    input wire rst_b_i,
    input wire [12:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire out_en_pin_i,
    input wire [NGROUPS-1:0] tone_a_irq_i,
    input wire [NGROUPS-1:0] tone_b_irq_i,
    input wire rout_oe_o,
    input wire sout_oe_o,
    input wire tone_irq_o,
    input wire [NGROUPS-1:0] grp_sel_o,
    input wire grp_wr_o,
    input wire [NGROUPS-1:0] power_on_o
);
    // ----------------------------------------
    // group 0 control write and its effects
    // ----------------------------------------
    wire ctl0_wr = wr_i && addr_i == 13'h0400;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_bcast_all_groups: assert property (ctl0_wr && wdata_i[7] ##1 wr_i && addr_i < 13'h0040
        |=> grp_wr_o && &grp_sel_o) else $error("broadcast did not select all groups");
    a_own_group_only: assert property (ctl0_wr && !wdata_i[7] ##1 wr_i && addr_i < 13'h0400
        |=> grp_sel_o == ({{(NGROUPS-1){1'b0}}, 1'b1} << $past(addr_i[12:6])))
        else $error("group select does not match address");
    a_upper_bits_group0: assert property (rd_i && addr_i > 13'h0400 && addr_i < 13'h0410
        |=> rdata_o[7:5] == 3'b000) else $error("global bits seen outside group 0");
    a_oe_both_high: assert property (ctl0_wr && wdata_i[6] ##1 out_en_pin_i
        |=> rout_oe_o && sout_oe_o) else $error("outputs not enabled");
    a_oe_pin_low: assert property (!out_en_pin_i |=> !rout_oe_o && !sout_oe_o)
        else $error("outputs driven with pin low");
    a_oe_bit_low: assert property (ctl0_wr && !wdata_i[6] |=> ##1 !rout_oe_o && !sout_oe_o)
        else $error("outputs driven with enable bit low");
    a_gmask_blocks: assert property (ctl0_wr && wdata_i[5] |=> ##1 !tone_irq_o)
        else $error("tone interrupt under global mask");
    a_tone_passes: assert property (ctl0_wr && wdata_i[5:3] == 3'b000 ##1 tone_a_irq_i[0]
        |=> tone_irq_o) else $error("tone interrupt lost");
    a_tone_a_masked: assert property (ctl0_wr && wdata_i[5:3] == 3'b001
        ##1 tone_a_irq_i == 1 && tone_b_irq_i == 0 |=> !tone_irq_o)
        else $error("masked tone A interrupt passed");
    a_reset_clears: assert property (disable iff (1'b0) !rst_b_i
        |=> !rout_oe_o && !tone_irq_o && power_on_o == 0 && rdata_o == 0)
        else $error("outputs not cleared by reset");
endmodule // egm_main_ctrl_props
bind egm_main_ctrl egm_main_ctrl_props #(.NGROUPS(NGROUPS)) u_props (.clock_i, .rst_b_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .out_en_pin_i, .tone_a_irq_i, .tone_b_irq_i,
    .rout_oe_o, .sout_oe_o, .tone_irq_o, .grp_sel_o, .grp_wr_o, .power_on_o);

// file: dv/tb_echo_group_main_control.sv
`timescale 1ns/100ps
module tb_echo_group_main_control;
    reg clock_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, out_en_pin_i = 0, rout_i = 1, sout_i = 0;
    reg [12:0] addr_i = 0;
    reg [7:0] wdata_i = 0;
    reg [15:0] tone_a_irq_i = 0, tone_b_irq_i = 0;
    wire [7:0] rdata_o, grp_wdata_o;
    wire rout_o, rout_oe_o, sout_o, sout_oe_o, tone_irq_o, irq_o, grp_wr_o;
    wire [15:0] grp_sel_o, power_on_o, format_o, law_o;
    wire [5:0] grp_addr_o;
    reg [7:0] d;
    int err_count = 0, comparisons = 0;
    egm_main_ctrl dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .out_en_pin_i(out_en_pin_i), .rout_i(rout_i), .sout_i(sout_i),
        .tone_a_irq_i(tone_a_irq_i), .tone_b_irq_i(tone_b_irq_i), .rout_o(rout_o),
        .rout_oe_o(rout_oe_o), .sout_o(sout_o), .sout_oe_o(sout_oe_o), .tone_irq_o(tone_irq_o),
        .irq_o(irq_o), .grp_sel_o(grp_sel_o), .grp_wr_o(grp_wr_o), .grp_addr_o(grp_addr_o),
        .grp_wdata_o(grp_wdata_o), .power_on_o(power_on_o), .format_o(format_o), .law_o(law_o));
    // ----------------------------------------
    // clock, bus tasks and compare
    // ----------------------------------------
    always #12.5 clock_i = ~clock_i;
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input [12:0] a, input [7:0] v);
        @(posedge clock_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
        @(posedge clock_i) wr_i <= 0;
    endtask
    task rd(input [12:0] a);
        @(posedge clock_i) {rd_i, addr_i} <= {1'b1, a};
        @(posedge clock_i) rd_i <= 0;
        #1 d = rdata_o;
    endtask
    task settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask
    task test_done;
        $display("err_count %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // watchdog and test sequence
    // ----------------------------------------
    initial begin
        #50000;
        err_count++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1;
        rd(13'h0400); chk("ctl0", d, 8'h00);
        chk("oe", {rout_oe_o, sout_oe_o}, 2'b00);
        rd(13'h07FF); chk("unmapped", d, 8'h00);
        chk("serial", {rout_o, sout_o}, 2'b10);
        @(posedge clock_i) out_en_pin_i <= 1;
        wr(13'h0400, 8'h40); settle; chk("oe", {rout_oe_o, sout_oe_o}, 2'b11);
        @(posedge clock_i) out_en_pin_i <= 0;
        settle; chk("oe", {rout_oe_o, sout_oe_o}, 2'b00);
        @(posedge clock_i) out_en_pin_i <= 1;
        wr(13'h0400, 8'h00); settle; chk("oe", {rout_oe_o, sout_oe_o}, 2'b00);
        wr(13'h0401, 8'hFF); rd(13'h0401); chk("ctl1", d, 8'h1F);
        chk("power", power_on_o, 16'h0002);
        chk("format", format_o, 16'h0002);
        chk("law", law_o, 16'h0002);
        wr(13'h0400, 8'h80); wr(13'h0400, 8'h81); settle;
        chk("power", power_on_o, 16'hFFFF);
        rd(13'h0401); chk("ctl1", d, 8'h01);
        wr(13'h0005, 8'h12); #1 chk("sel", grp_sel_o, 16'hFFFF);
        chk("grp_bus", {grp_wr_o, grp_addr_o, grp_wdata_o}, {1'b1, 6'h05, 8'h12});
        wr(13'h0400, 8'h01); wr(13'h00C5, 8'h12); #1 chk("sel", grp_sel_o, 16'h0008);
        @(posedge clock_i) tone_a_irq_i <= 16'h0001;
        settle; chk("tone", tone_irq_o, 1);
        wr(13'h0400, 8'h21); settle; chk("tone", tone_irq_o, 0);
        wr(13'h0400, 8'h09); settle; chk("tone", tone_irq_o, 0);
        @(posedge clock_i) {tone_a_irq_i, tone_b_irq_i} <= {16'h0000, 16'h0001};
        settle; chk("tone", tone_irq_o, 1);
        wr(13'h0400, 8'h11); settle; chk("tone", tone_irq_o, 0);
        @(posedge clock_i) tone_b_irq_i <= 16'h0000;
        wr(13'h0411, 8'h01); wr(13'h0410, 8'h03); wr(13'h0400, 8'h00);
        settle; chk("irq", irq_o, 1);
        rd(13'h0410); chk("status", d[0], 1);
        wr(13'h0410, 8'h01); settle; chk("irq", irq_o, 0);
        wr(13'h0411, 8'h00); wr(13'h0400, 8'h00); settle; chk("irq", irq_o, 0);
        rd(13'h0410); chk("status", d[0], 1);
        test_done;
    end
endmodule // tb_echo_group_main_control
